/* logic/cssq_sequencer.sv */
// Search step sequencer: step tables, maps, pointer and register port
//
// What this block does and what software must set up
// RL1: Each step compares key only against its own selected segment.
// RL2: Key bits with mask bit one are excluded and always match.
// RL3: Head step hits alone; other steps AND with earlier group results.
// RL4: Software sets the head flag on the first step of every sequence.
// RL5: Head step discards earlier result; read intermediates before it.
// RL6: Marking step sets access bit of every hit entry; else bits hold.
// RL7: Access bits stay set until purge or clear-marks command.
// RL8: Software should enable marking only on the last AND-group step.
// RL9: After a last-flagged step, ignore write pulses until pointer reset.
// RL10: Software places a last flag on a reachable step.
// RL11: Two channels of eight steps and masks, each with own maps.
// RL12: Pointer starts at start number, runs steps, stops one past the last-flagged step.
// RL13: Active channel's single cut and search-start maps drive capture.
// RL14: Software marks enough search-start positions for longest sequence.
// RL15: Every search-start block is also flagged in the cut map; unchecked here, a block set only in the search-start map idles.
// RL16: Inactive channel config stays reachable through the register port.
// RL17: Segment numbers agree with table layout; avoid code seven there.
// RL18: Software should program unused step and map registers.
// RL19: Pointer reset loads start number and returns block tracking to 0.
// RL20: Sequence starts on first pulse; pointer advances per search step.
// RL21: Steps, masks and maps reset to fixed defaults.
`timescale 1ns/10ps
module cssq_sequencer
(
   // Clock and reset
   input wire logic                   clk_sys,
   input wire logic                   rst_n,
   // Register port
   input wire logic [cssq_pkg::AW-1:0] reg_addr,
   input wire logic [31:0]            reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   output logic [31:0]                reg_rdata,
   // Data source
   input wire logic                   wr_pulse,
   input wire logic [31:0]            key_in,
   input wire logic                   pointer_reset_pin_n,
   // Sequence state
   output logic                       seq_active,
   output logic                       seq_done
);
   import cssq_pkg::*;

   cssq_srch_if sif ();

   cssq_match_array u_arr
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .sif     (sif.arr)
   );

   cssq_step_type step_r   [CHANS][STEPS];
   cssq_step_type step_nxt [CHANS][STEPS];
   logic [31:0]   mask_r   [CHANS][STEPS];
   logic [31:0]   mask_nxt [CHANS][STEPS];
   logic [63:0]   cut_r    [CHANS];
   logic [63:0]   cut_nxt  [CHANS];
   logic [63:0]   ss_r     [CHANS];
   logic [63:0]   ss_nxt   [CHANS];
   logic          ch_sel_r, ch_sel_nxt;
   logic [2:0]    start_r, start_nxt;
   logic          act_ch_r, act_ch_nxt;
   logic [2:0]    ptr_r, ptr_nxt;
   logic [5:0]    blk_r, blk_nxt;
   logic [2:0]    last_r, last_nxt;
   cssq_seq_type  state_r, state_nxt;
   logic          active_r, active_nxt;
   logic [31:0]   rdata_r, rdata_nxt;

   logic [3:0]    page;
   logic [7:0]    low;
   logic          ch_a;
   logic          cmd_wr;
   logic          prst;
   logic          pulse_ok;
   logic          fire_c;
   cssq_step_type cur_step;

   assign page = reg_addr[11:8];
   assign low  = reg_addr[7:0];
   // Register port reaches both channels whatever is active
   assign ch_a = (page == PG_MAP) ? reg_addr[4] : reg_addr[5];    // [RL16]
   assign cmd_wr = reg_wr && page == PG_CTL && low == A_CMD;
   assign prst = !pointer_reset_pin_n ||
                 (cmd_wr && reg_wdata[CMD_PRST]);                 // [RL19]

   // Only the active channel's steps and maps take part in searches
   assign cur_step = step_r[act_ch_r][ptr_r];                     // [RL11]
   assign pulse_ok = wr_pulse && state_r != SQ_DONE && !prst;     // [RL9]
   assign fire_c   = pulse_ok && ss_r[act_ch_r][blk_r] &&         // [RL13]
                     cut_r[act_ch_r][blk_r];

   // Search request toward the array
   assign sif.fire      = fire_c;
   assign sif.step      = cur_step;
   assign sif.mask      = mask_r[act_ch_r][ptr_r];                // [RL2]
   assign sif.key       = key_in;
   assign sif.tbl_we    = reg_wr && page == PG_TBL && !reg_addr[7];
   assign sif.tbl_ent   = reg_addr[6:5];
   assign sif.tbl_seg   = reg_addr[4:2];
   assign sif.tbl_wdata = reg_wdata;
   assign sif.vld_we    = reg_wr && page == PG_CTL && low == A_VALID;
   assign sif.vld_wdata = reg_wdata[3:0];
   assign sif.clr_marks = cmd_wr && reg_wdata[CMD_CLR];          // [RL7]
   assign sif.purge_m   = cmd_wr && reg_wdata[CMD_PM];
   assign sif.purge_u   = cmd_wr && reg_wdata[CMD_PU];

   // Configuration writes
   always_comb
   begin
      step_nxt   = step_r;
      mask_nxt   = mask_r;
      cut_nxt    = cut_r;
      ss_nxt     = ss_r;
      ch_sel_nxt = ch_sel_r;
      start_nxt  = start_r;
      if (reg_wr)
      begin
         case (page)
            PG_CTL:
            begin
               if (low == A_CTRL)
               begin
                  ch_sel_nxt = reg_wdata[CTRL_CH];
                  start_nxt  = reg_wdata[CTRL_START +: 3];
               end
            end
            PG_STEP:
               step_nxt[ch_a][reg_addr[4:2]] = reg_wdata[5:0];
            PG_MASK:
               mask_nxt[ch_a][reg_addr[4:2]] = reg_wdata;
            PG_MAP:
            begin
               case (reg_addr[3:2])
                  2'h0: cut_nxt[ch_a][31:0]  = reg_wdata;
                  2'h1: cut_nxt[ch_a][63:32] = reg_wdata;
                  2'h2: ss_nxt[ch_a][31:0]   = reg_wdata;
                  default: ss_nxt[ch_a][63:32] = reg_wdata;
               endcase
            end
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         step_r   <= '{default: STEP_RST};                        // [RL21]
         mask_r   <= '{default: MASK_RST};                        // [RL21]
         cut_r    <= '{default: MAP_RST};                         // [RL21]
         ss_r     <= '{default: MAP_RST};                         // [RL21]
         ch_sel_r <= 1'b0;
         start_r  <= START_RST;
      end
      else
      begin
         step_r   <= step_nxt;
         mask_r   <= mask_nxt;
         cut_r    <= cut_nxt;
         ss_r     <= ss_nxt;
         ch_sel_r <= ch_sel_nxt;
         start_r  <= start_nxt;
      end
   end

   // Sequence pointer and block tracking
   always_comb
   begin
      state_nxt  = state_r;
      ptr_nxt    = ptr_r;
      blk_nxt    = blk_r;
      last_nxt   = last_r;
      act_ch_nxt = act_ch_r;
      if (prst)
      begin
         // Channel and start take effect only here, never mid-sequence
         state_nxt  = SQ_IDLE;
         ptr_nxt    = start_r;                                    // [RL19]
         blk_nxt    = 6'h00;                                      // [RL19]
         act_ch_nxt = ch_sel_r;
      end
      else if (pulse_ok)
      begin
         state_nxt = SQ_RUN;                                      // [RL20]
         blk_nxt   = blk_r + 6'h01;
         if (fire_c)
         begin
            ptr_nxt  = ptr_r + 3'h1;                              // [RL20]
            last_nxt = ptr_r;
            if (cur_step.last)
               state_nxt = SQ_DONE;                               // [RL9] [RL12]
         end
      end
      active_nxt = (state_nxt == SQ_RUN);
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r  <= SQ_IDLE;
         ptr_r    <= START_RST;
         blk_r    <= 6'h00;
         last_r   <= 3'h0;
         act_ch_r <= 1'b0;
         active_r <= 1'b0;
      end
      else
      begin
         state_r  <= state_nxt;
         ptr_r    <= ptr_nxt;
         blk_r    <= blk_nxt;
         last_r   <= last_nxt;
         act_ch_r <= act_ch_nxt;
         active_r <= active_nxt;
      end
   end

   // Read data stand only in the cycle after the strobe
   always_comb
   begin
      rdata_nxt = 32'h0;
      if (reg_rd)
      begin
         case (page)
            PG_CTL:
            begin
               case (low)
                  A_CTRL:
                  begin
                     rdata_nxt[CTRL_CH]         = ch_sel_r;
                     rdata_nxt[CTRL_START +: 3] = start_r;
                  end
                  A_STAT:
                  begin
                     rdata_nxt[ST_PTR +: 3]  = ptr_r;
                     rdata_nxt[ST_ACT]       = active_r;
                     rdata_nxt[ST_DONE]      = state_r == SQ_DONE;
                     rdata_nxt[ST_HIT]       = sif.grp_hit;
                     rdata_nxt[ST_CH]        = act_ch_r;
                     rdata_nxt[ST_LAST +: 3] = last_r;
                  end
                  A_HITS:  rdata_nxt[3:0] = sif.hits;
                  A_MARKS: rdata_nxt[3:0] = sif.marks;
                  A_VALID: rdata_nxt[3:0] = sif.valid;
                  default: rdata_nxt = 32'h0;
               endcase
            end
            PG_STEP:
               rdata_nxt[5:0] = step_r[ch_a][reg_addr[4:2]];
            PG_MASK:
               rdata_nxt = mask_r[ch_a][reg_addr[4:2]];
            PG_MAP:
            begin
               case (reg_addr[3:2])
                  2'h0: rdata_nxt = cut_r[ch_a][31:0];
                  2'h1: rdata_nxt = cut_r[ch_a][63:32];
                  2'h2: rdata_nxt = ss_r[ch_a][31:0];
                  default: rdata_nxt = ss_r[ch_a][63:32];
               endcase
            end
            PG_TBL:
               rdata_nxt = reg_addr[7] ? 32'h0 : sif.tbl_rdata;
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rdata_r <= 32'h0;
      else
         rdata_r <= rdata_nxt;
   end

   assign reg_rdata  = rdata_r;
   assign seq_active = active_r;
   assign seq_done   = state_r[1];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   ptr_reset_a: assert property (prst |=>                          // [RL19]
      ptr_r == $past(start_r) && blk_r == 6'h00 && !seq_done)
      else $error("pointer reset did not load start");
   done_hold_a: assert property (seq_done && !prst |=>             // [RL9]
      seq_done && $stable(ptr_r) && $stable(blk_r))
      else $error("pulse acted after sequence end");
   ptr_step_a: assert property (fire_c && !cur_step.last |=>       // [RL20]
      ptr_r == 3'($past(ptr_r) + 3'h1) && seq_active)
      else $error("pointer did not advance by one");
   // A pointer reset right after the last step may end the hold early
   last_stop_a: assert property (fire_c && cur_step.last |=>       // [RL12]
      seq_done ##1 (seq_done || $past(prst)))
      else $error("last step did not end sequence");
   map_gate_a: assert property (pulse_ok &&                        // [RL13]
      !(ss_r[act_ch_r][blk_r] && cut_r[act_ch_r][blk_r]) |=>
      $stable(ptr_r) && blk_r == 6'($past(blk_r) + 6'h01))
      else $error("pulse off the maps ran a step");
   start_run_a: assert property (!seq_active && !seq_done &&       // [RL20]
      wr_pulse && !prst |=> seq_active || seq_done)
      else $error("first pulse did not start sequence");
   fire_cover_c: cover property (fire_c && !cur_step.last ##[1:20]
      fire_c && cur_step.last);
   done_cover_c: cover property (seq_done ##1 prst);
   chan_cover_c: cover property (act_ch_r && fire_c);
endmodule

/* include/cssq_pkg.sv */
// Constants and types for the search step sequencer
package cssq_pkg;
   localparam int STEPS   = 8;
   localparam int CHANS   = 2;
   localparam int ENTRIES = 4;
   localparam int SEGS    = 8;
   localparam int AW      = 12;
   // Register page in addr[11:8], fixed words in page 0
   localparam logic [3:0]  PG_CTL  = 4'h0;
   localparam logic [3:0]  PG_STEP = 4'h1;
   localparam logic [3:0]  PG_MASK = 4'h2;
   localparam logic [3:0]  PG_MAP  = 4'h3;
   localparam logic [3:0]  PG_TBL  = 4'h4;
   localparam logic [7:0]  A_CTRL  = 8'h00;
   localparam logic [7:0]  A_CMD   = 8'h04;
   localparam logic [7:0]  A_STAT  = 8'h08;
   localparam logic [7:0]  A_HITS  = 8'h0c;
   localparam logic [7:0]  A_MARKS = 8'h10;
   localparam logic [7:0]  A_VALID = 8'h14;
   // Field positions
   localparam int CTRL_CH    = 0;
   localparam int CTRL_START = 1;
   localparam int CMD_PRST   = 0;
   localparam int CMD_CLR    = 1;
   localparam int CMD_PM     = 2;
   localparam int CMD_PU     = 3;
   localparam int ST_PTR     = 0;
   localparam int ST_ACT     = 3;
   localparam int ST_DONE    = 4;
   localparam int ST_HIT     = 5;
   localparam int ST_CH      = 6;
   localparam int ST_LAST    = 8;
   // Reset values
   localparam logic [5:0]  STEP_RST  = 6'h28;
   localparam logic [31:0] MASK_RST  = 32'h0000_0000;
   localparam logic [63:0] MAP_RST   = 64'h0;
   localparam logic [2:0]  START_RST = 3'h0;
   typedef struct packed {
      logic       last;
      logic       mark;
      logic       head;
      logic [2:0] seg;
   } cssq_step_type;
   typedef enum logic [1:0] {
      SQ_IDLE = 2'b00,
      SQ_RUN  = 2'b01,
      SQ_DONE = 2'b11
   } cssq_seq_type;
endpackage

/* include/cssq_srch_if.sv */
// Search request and table access between sequencer and match array
`timescale 1ns/10ps
interface cssq_srch_if;
   import cssq_pkg::*;
   logic          fire;
   cssq_step_type step;
   logic [31:0]   mask;
   logic [31:0]   key;
   logic          tbl_we;
   logic [1:0]    tbl_ent;
   logic [2:0]    tbl_seg;
   logic [31:0]   tbl_wdata;
   logic          vld_we;
   logic [3:0]    vld_wdata;
   logic          clr_marks;
   logic          purge_m;
   logic          purge_u;
   logic [31:0]   tbl_rdata;
   logic [3:0]    hits;
   logic [3:0]    marks;
   logic [3:0]    valid;
   logic          grp_hit;
   modport ctl (output fire, step, mask, key, tbl_we, tbl_ent, tbl_seg,
                tbl_wdata, vld_we, vld_wdata, clr_marks, purge_m, purge_u,
                input tbl_rdata, hits, marks, valid, grp_hit);
   modport arr (input fire, step, mask, key, tbl_we, tbl_ent, tbl_seg,
                tbl_wdata, vld_we, vld_wdata, clr_marks, purge_m, purge_u,
                output tbl_rdata, hits, marks, valid, grp_hit);
endinterface

/* logic/cssq_match_array.sv */
// Entry table, per-entry compare, AND accumulation and access marks
`timescale 1ns/10ps
module cssq_match_array
(
   // Clock and reset
   input wire logic   clk_sys,
   input wire logic   rst_n,
   // Sequencer side
   cssq_srch_if.arr   sif
);
   import cssq_pkg::*;

   logic [31:0]        tbl_r   [ENTRIES][SEGS];
   logic [31:0]        tbl_nxt [ENTRIES][SEGS];
   logic [ENTRIES-1:0] valid_r, valid_nxt;
   logic [ENTRIES-1:0] marks_r, marks_nxt;
   logic [ENTRIES-1:0] acc_r, acc_nxt;
   logic [ENTRIES-1:0] hit_now;
   logic               grp_r, grp_nxt;

   // Masked bits never mismatch; only the step's segment is compared
   for (genvar e = 0; e < ENTRIES; e++)
   begin : g_ent
      assign hit_now[e] = valid_r[e] &                           // [RL1]
         (((tbl_r[e][sif.step.seg] ^ sif.key) & ~sif.mask) == 32'h0); // [RL2]
   end

   always_comb
   begin
      tbl_nxt   = tbl_r;
      valid_nxt = valid_r;
      marks_nxt = marks_r;
      acc_nxt   = acc_r;
      grp_nxt   = grp_r;
      if (sif.tbl_we)
         tbl_nxt[sif.tbl_ent][sif.tbl_seg] = sif.tbl_wdata;
      if (sif.vld_we)
         valid_nxt = sif.vld_wdata;
      // Purges also wipe the marks; searches never clear them
      if (sif.purge_m)
      begin
         valid_nxt = valid_nxt & ~marks_r;
         marks_nxt = '0;                                          // [RL7]
      end
      if (sif.purge_u)
      begin
         valid_nxt = valid_nxt & marks_r;
         marks_nxt = '0;                                          // [RL7]
      end
      if (sif.clr_marks)
         marks_nxt = '0;                                          // [RL7]
      if (sif.fire)
      begin
         // A head step drops the earlier group result
         acc_nxt = sif.step.head ? hit_now : (acc_r & hit_now);   // [RL3] [RL5]
         grp_nxt = |acc_nxt;
         // Applied after the clears so a same-cycle set wins
         if (sif.step.mark)
            marks_nxt = marks_nxt | acc_nxt;                      // [RL6]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tbl_r   <= '{default: '0};
         valid_r <= '0;
         marks_r <= '0;
         acc_r   <= '0;
         grp_r   <= 1'b0;
      end
      else
      begin
         tbl_r   <= tbl_nxt;
         valid_r <= valid_nxt;
         marks_r <= marks_nxt;
         acc_r   <= acc_nxt;
         grp_r   <= grp_nxt;
      end
   end

   assign sif.tbl_rdata = tbl_r[sif.tbl_ent][sif.tbl_seg];
   assign sif.hits      = acc_r;
   assign sif.marks     = marks_r;
   assign sif.valid     = valid_r;
   assign sif.grp_hit   = grp_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   head_fresh_a: assert property (sif.fire && sif.step.head |=>  // [RL3]
      acc_r == $past(hit_now)) else $error("head step kept old result");
   and_chain_a: assert property (sif.fire && !sif.step.head |=>  // [RL3]
      (acc_r & ~$past(acc_r)) == '0) else $error("AND step gained hits");
   mask_all_a: assert property (sif.fire && sif.step.head &&     // [RL2]
      sif.mask == 32'hffff_ffff |=> acc_r == $past(valid_r))
      else $error("full mask did not hit all valid entries");
   mark_set_a: assert property (sif.fire && sif.step.mark |=>    // [RL6]
      (marks_r & acc_r) == acc_r) else $error("hit entry not marked");
   mark_hold_a: assert property (!sif.fire && !sif.clr_marks &&  // [RL6]
      !sif.purge_m && !sif.purge_u && !sif.vld_we |=> $stable(marks_r))
      else $error("marks changed without cause");
   mark_keep_a: assert property (!sif.clr_marks && !sif.purge_m && // [RL7]
      !sif.purge_u |=> ($past(marks_r) & ~marks_r) == '0)
      else $error("mark cleared by a search");
   and_cover_c: cover property (sif.fire && !sif.step.head &&
      |acc_r ##1 grp_r);
   mark_cover_c: cover property (sif.fire && sif.step.mark ##1 |marks_r);
endmodule

/* bench/cssq_source.sv */
// Data source model that strobes formatted words into the sequencer
`timescale 1ns/10ps
module cssq_source
(
   // Clock
   input wire logic    clk_sys,
   // Strobe side
   output logic        wr_pulse,
   output logic [31:0] key_in
);
   initial
   begin
      wr_pulse = 1'b0;
      key_in   = 32'h0;
   end

   // Word lines are not held after a strobe, so stale keys cannot match
   task automatic burst(input int n, input int gap, input logic [31:0] k);
      for (int i = 0; i < n; i++)
      begin
         wr_pulse <= 1'b1;
         key_in   <= k;
         @(posedge clk_sys);
         if (gap > 0 || i == n - 1)
         begin
            wr_pulse <= 1'b0;
            key_in   <= ~k;
            repeat (gap) @(posedge clk_sys);
         end
      end
   endtask
endmodule

/* bench/testbench.sv */
// Self-checking bench for the search step sequencer
`timescale 1ns/10ps
module testbench;
   import cssq_pkg::*;
   logic          clk_sys;
   logic          rst_n;
   logic [AW-1:0] reg_addr;
   logic [31:0]   reg_wdata;
   logic          reg_wr;
   logic          reg_rd;
   logic [31:0]   reg_rdata;
   logic          wr_pulse;
   logic [31:0]   key_in;
   logic          pointer_reset_pin_n;
   logic          seq_active;
   logic          seq_done;
   int            error_cnt;
   int            comparisons;
   int            cycles;

   cssq_sequencer u_dut
   (
      .clk_sys             (clk_sys),
      .rst_n               (rst_n),
      .reg_addr            (reg_addr),
      .reg_wdata           (reg_wdata),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .reg_rdata           (reg_rdata),
      .wr_pulse            (wr_pulse),
      .key_in              (key_in),
      .pointer_reset_pin_n (pointer_reset_pin_n),
      .seq_active          (seq_active),
      .seq_done            (seq_done)
   );

   cssq_source u_src
   (
      .clk_sys  (clk_sys),
      .wr_pulse (wr_pulse),
      .key_in   (key_in)
   );

   initial clk_sys = 1'b0;
   always #50 clk_sys = ~clk_sys;

   // The whole run needs well under two thousand cycles
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [AW-1:0] adr(input logic [3:0] pg, input int o);
      return {pg, 8'(o)};
   endfunction

   function automatic logic [31:0] sd(input int s, input bit h, input bit m,
                                      input bit l);
      return {26'h0, l, m, h, 3'(s)};
   endfunction

   function automatic logic [31:0] td(input int e, input int s);
      return {12'h0, 4'(e), 16'h1000 + 16'(s)};
   endfunction

   // An idle cycle after each write keeps strobe edges apart
   task automatic reg_write(input logic [AW-1:0] a, input logic [31:0] d);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic reg_read(input logic [AW-1:0] a, output logic [31:0] d);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk_sys);
   endtask

   task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] exp);
      logic [31:0] d;
      reg_read(a, d);
      check(d, exp);
   endtask

   task automatic stchk(input int p, input bit a, input bit dn, input bit c);
      logic [31:0] d;
      logic [31:0] e;
      reg_read(adr(PG_CTL, A_STAT), d);
      e = 32'h0;
      e[ST_PTR +: 3] = 3'(p);
      e[ST_ACT] = a;
      e[ST_DONE] = dn;
      e[ST_CH] = c;
      check(d & 32'h0000_005f, e);
   endtask

   task automatic run(input logic [31:0] ctl, input int n, input int gap,
                      input logic [31:0] k);
      reg_write(adr(PG_CTL, A_CTRL), ctl);
      reg_write(adr(PG_CTL, A_CMD), 32'h1);
      u_src.burst(n, gap, k);
      @(posedge clk_sys);
   endtask

   task automatic t_defaults();
      for (int i = 0; i < 16; i++)
      begin
         rdchk(adr(PG_STEP, i * 4), {26'h0, STEP_RST});
         rdchk(adr(PG_MASK, i * 4), MASK_RST);
      end
      for (int i = 0; i < 8; i++)
         rdchk(adr(PG_MAP, i * 4), 32'h0);
      stchk(0, 0, 0, 0);
      rdchk(adr(PG_CTL, 8'hf0), 32'h0);
   endtask

   task automatic t_segment_mask();
      for (int e = 0; e < 4; e++)
         for (int s = 0; s < 8; s++)
            reg_write(adr(PG_TBL, e * 32 + s * 4), td(e, s));
      reg_write(adr(PG_CTL, A_VALID), 32'hf);
      reg_write(adr(PG_MAP, 0), 32'h1);
      reg_write(adr(PG_MAP, 8), 32'h1);
      reg_write(adr(PG_STEP, 0), sd(2, 1, 0, 1));
      run(32'h0, 1, 0, td(1, 2));
      rdchk(adr(PG_CTL, A_HITS), 32'h2);
      stchk(1, 0, 1, 0);
      reg_write(adr(PG_STEP, 0), sd(3, 1, 0, 1));
      run(32'h0, 1, 0, td(1, 2));
      rdchk(adr(PG_CTL, A_HITS), 32'h0);
      reg_write(adr(PG_STEP, 0), sd(2, 1, 0, 1));
      reg_write(adr(PG_MASK, 0), 32'hffff_0000);
      run(32'h0, 1, 0, td(0, 2));
      rdchk(adr(PG_CTL, A_HITS), 32'hf);
      reg_write(adr(PG_MASK, 0), 32'hffff_ffff);
      reg_write(adr(PG_CTL, A_VALID), 32'hb);
      run(32'h0, 1, 0, td(0, 2));
      rdchk(adr(PG_CTL, A_HITS), 32'hb);
      reg_write(adr(PG_CTL, A_VALID), 32'hf);
      reg_write(adr(PG_MASK, 0), 32'h0);
   endtask

   // Head first, marking only on the closing step of the group
   task automatic t_and_marks();
      reg_write(adr(PG_STEP, 0), sd(1, 1, 0, 0));
      reg_write(adr(PG_STEP, 4), sd(2, 0, 1, 1));
      reg_write(adr(PG_MASK, 4), 32'hffff_ffff);
      reg_write(adr(PG_MAP, 0), 32'h7);
      reg_write(adr(PG_MAP, 8), 32'h7);
      run(32'h0, 3, 0, td(1, 1));
      rdchk(adr(PG_CTL, A_HITS), 32'h2);
      rdchk(adr(PG_CTL, A_MARKS), 32'h2);
      stchk(2, 0, 1, 0);
      check({30'h0, seq_active, seq_done}, 32'h1);
      run(32'h0, 2, 1, td(2, 1));
      rdchk(adr(PG_CTL, A_HITS), 32'h4);
      rdchk(adr(PG_CTL, A_MARKS), 32'h6);
      reg_write(adr(PG_CTL, A_CMD), 32'h2);
      rdchk(adr(PG_CTL, A_MARKS), 32'h0);
      run(32'h0, 2, 0, td(2, 1));
      reg_write(adr(PG_CTL, A_CMD), 32'h4);
      rdchk(adr(PG_CTL, A_VALID), 32'hb);
      rdchk(adr(PG_CTL, A_MARKS), 32'h0);
      reg_write(adr(PG_CTL, A_VALID), 32'hf);
      run(32'h0, 2, 0, td(2, 1));
      reg_write(adr(PG_CTL, A_CMD), 32'h8);
      rdchk(adr(PG_CTL, A_VALID), 32'h4);
      rdchk(adr(PG_CTL, A_MARKS), 32'h0);
      reg_write(adr(PG_CTL, A_VALID), 32'hf);
   endtask

   // Block 1 is a search-start position without capture, so it must idle
   task automatic t_channel_b();
      logic [31:0] d;
      reg_write(adr(PG_STEP, 52), sd(3, 1, 0, 1));
      reg_write(adr(PG_MAP, 16), 32'h5);
      reg_write(adr(PG_MAP, 24), 32'h6);
      run(32'hb, 1, 2, td(3, 3));
      stchk(5, 1, 0, 1);
      u_src.burst(1, 0, td(3, 3));
      @(posedge clk_sys);
      stchk(5, 1, 0, 1);
      u_src.burst(1, 3, td(3, 3));
      @(posedge clk_sys);
      stchk(6, 0, 1, 1);
      rdchk(adr(PG_CTL, A_HITS), 32'h8);
      reg_read(adr(PG_CTL, A_STAT), d);
      check({29'h0, d[ST_LAST +: 3]}, 32'h5);
      rdchk(adr(PG_STEP, 4), sd(2, 0, 1, 1));
      reg_write(adr(PG_MASK, 12), 32'h1234_5678);
      rdchk(adr(PG_MASK, 12), 32'h1234_5678);
      pointer_reset_pin_n <= 1'b0;
      @(posedge clk_sys);
      pointer_reset_pin_n <= 1'b1;
      @(posedge clk_sys);
      stchk(5, 0, 0, 1);
      check({31'h0, seq_done}, 32'h0);
      rdchk(adr(PG_CTL, A_CTRL), 32'hb);
   endtask

   initial
   begin
      error_cnt           = 0;
      comparisons         = 0;
      cycles              = 0;
      rst_n               = 1'b0;
      reg_addr            = '0;
      reg_wdata           = 32'h0;
      reg_wr              = 1'b0;
      reg_rd              = 1'b0;
      pointer_reset_pin_n = 1'b1;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_defaults();
      t_segment_mask();
      t_and_marks();
      t_channel_b();
      report_and_stop();
   end
endmodule
